//--- common/rfr_cfg.svh
// Constants of the router path select link: addresses, codes, timing.
// Assumes inclusion by both ends and the testbench; definitions only.
`ifndef RFR_CFG_SVH
`define RFR_CFG_SVH

// Link device address, value arbitrary
`define RFR_DEV_ADDR 7'h2c
`define RFR_NUM_IN 3
`define RFR_NUM_OUT 5
// Highest output allowed for input 1; input n adds n-1
`define RFR_MAX_OUT_IN1 8'h03
// Switch codes, bit 3 down to bit 0
`define RFR_CODE_OUT1 4'he
`define RFR_CODE_OUT2 4'hd
`define RFR_CODE_OUT3 4'hc
`define RFR_CODE_OUT4 4'hb
`define RFR_CODE_OUT5 4'ha
`define RFR_CODE_OFF 4'hf
`define RFR_WORD_RST 8'h00

// Controller registers, byte addresses
`define RFR_REG_CTRL 8'h00
`define RFR_REG_WORDS 8'h04
`define RFR_REG_STAT 8'h08
`define RFR_CTRL_GO 0
`define RFR_CTRL_CASC 1
`define RFR_CTRL_USED_LO 2
`define RFR_CTRL_NEED 5
`define RFR_WORD_W 3
`define RFR_WORD_STRIDE 4
`define RFR_STAT_BUSY 0
`define RFR_STAT_NACK 1
`define RFR_STAT_DONE 2
// Output of router 1 that feeds router 2 when cascaded
`define RFR_CASC_OUT 3'h1

// Link timing
`define RFR_PCLK_HZ 100000000
`define RFR_LINK_HZ 100000
`define RFR_QTR_CYC ((`RFR_PCLK_HZ) / (4 * (`RFR_LINK_HZ)))
`define RFR_QTR_W 9

`endif

//--- common/rfr_link_if.sv
// Two-wire open-drain link between controller and router.
// Assumes pull-ups: a line is low when any party enables its low drive.
`timescale 1ns/1ps
`default_nettype none
interface rfr_link_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    assign scl = !(!host_scl_oe_n && !host_scl_o);
    assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

    modport host (output host_scl_o, output host_scl_oe_n, output host_sda_o, output host_sda_oe_n,
                  input scl, input sda);
    modport dev (output dev_sda_o, output dev_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

//--- common/rfr_pkg.sv
// Types shared by both ends of the router path select link.
// Assumes rfr_cfg.svh holds the numeric constants.
`default_nettype none
package rfr_pkg;
    typedef logic [7:0] rfr_word_t;
    typedef logic [3:0] rfr_code_t;
    typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_AACK, DS_WR, DS_WACK, DS_TX, DS_RACK} rfr_dev_st_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} rfr_host_st_t;
endpackage
`default_nettype wire

//--- src/rfr_route_ctrl.sv
// Controller end: APB registers and link master sending three route words.
// Assumes APB master on pclk and a router that never stretches the clock.
`timescale 1ns/1ps
`default_nettype none
`include "rfr_cfg.svh"
module rfr_route_ctrl
    import rfr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    rfr_link_if.host link
);

    rfr_host_st_t st_ff;
    logic [`RFR_QTR_W-1:0] div_ff;
    logic tick;
    logic [1:0] phase_ff;
    logic [3:0] bit_ff;
    logic [1:0] byte_ff;
    logic [3:0][7:0] tx_ff;
    logic scl_oe_n_ff;
    logic sda_oe_n_ff;
    logic nack_ff;
    logic casc_ff;
    logic need_ff;
    logic [2:0] used_ff;
    logic [2:0][2:0] words_ff;
    logic stat_nack_ff;
    logic stat_done_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic acc;
    logic go;
    logic set_nack;
    logic set_done;
    logic map_ok;

    assign acc = psel && penable && pready_ff;
    assign go = acc && pwrite && paddr == `RFR_REG_CTRL && pwdata[`RFR_CTRL_GO] && st_ff == HS_IDLE;
    assign map_ok = paddr == `RFR_REG_CTRL || paddr == `RFR_REG_WORDS || paddr == `RFR_REG_STAT;

    // One wait state on every access; data and error ready when pready rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !map_ok;
            prdata_ff <= 32'h0;
            if (psel && penable && !pready_ff && !pwrite) begin
                unique case (paddr)
                    `RFR_REG_CTRL: prdata_ff <= {26'h0, need_ff, used_ff, casc_ff, 1'b0};
                    `RFR_REG_WORDS: prdata_ff <= {21'h0, words_ff[2], 1'b0, words_ff[1], 1'b0, words_ff[0]};
                    `RFR_REG_STAT: prdata_ff <= {29'h0, stat_done_ff, stat_nack_ff, st_ff != HS_IDLE};
                    default: prdata_ff <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            casc_ff <= 1'b0;
            need_ff <= 1'b0;
            used_ff <= 3'h0;
            words_ff <= '0;
        end else if (acc && pwrite) begin
            if (paddr == `RFR_REG_CTRL) begin
                casc_ff <= pwdata[`RFR_CTRL_CASC];
                need_ff <= pwdata[`RFR_CTRL_NEED];
                used_ff <= pwdata[`RFR_CTRL_USED_LO +: 3];
            end
            if (paddr == `RFR_REG_WORDS) begin
                for (int i = 0; i < 3; i++) begin
                    words_ff[i] <= pwdata[i*`RFR_WORD_STRIDE +: `RFR_WORD_W];
                end
            end
        end
    end

    // Sticky status: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_nack_ff <= 1'b0;
            stat_done_ff <= 1'b0;
        end else begin
            if (set_nack) begin
                stat_nack_ff <= 1'b1;
            end else if (acc && pwrite && paddr == `RFR_REG_STAT && pwdata[`RFR_STAT_NACK]) begin
                stat_nack_ff <= 1'b0;
            end
            if (set_done) begin
                stat_done_ff <= 1'b1;
            end else if (acc && pwrite && paddr == `RFR_REG_STAT && pwdata[`RFR_STAT_DONE]) begin
                stat_done_ff <= 1'b0;
            end
        end
    end

    // Quarter bit period enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
        end else if (st_ff == HS_IDLE || div_ff == `RFR_QTR_W'(`RFR_QTR_CYC - 1)) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + `RFR_QTR_W'(1);
        end
    end
    assign tick = st_ff != HS_IDLE && div_ff == `RFR_QTR_W'(`RFR_QTR_CYC - 1);
    assign set_nack = tick && st_ff == HS_BIT && phase_ff == 2'd2 && bit_ff == 4'h8 && link.sda;
    assign set_done = tick && st_ff == HS_STOP && phase_ff == 2'd3;

    // Frame: start, address, word 1, word 2, word 3, stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= HS_IDLE;
            phase_ff <= 2'd0;
            bit_ff <= 4'h0;
            byte_ff <= 2'd0;
            tx_ff <= '0;
            scl_oe_n_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
            nack_ff <= 1'b0;
        end else if (go) begin
            st_ff <= HS_START;
            phase_ff <= 2'd0;
            bit_ff <= 4'h0;
            byte_ff <= 2'd0;
            nack_ff <= 1'b0;
            tx_ff[0] <= {`RFR_DEV_ADDR, 1'b0};
            // Mask and cascade bits come from the GO write itself, as their registers update only at this edge
            tx_ff[1] <= pwdata[`RFR_CTRL_USED_LO] ? {5'h0, words_ff[0]} : 8'h00;
            tx_ff[2] <= pwdata[`RFR_CTRL_USED_LO + 1] ? {5'h0, words_ff[1]} : 8'h00;
            if (pwdata[`RFR_CTRL_CASC]) begin
                tx_ff[3] <= pwdata[`RFR_CTRL_NEED] ? {5'h0, `RFR_CASC_OUT} : 8'h00;
            end else begin
                tx_ff[3] <= pwdata[`RFR_CTRL_USED_LO + 2] ? {5'h0, words_ff[2]} : 8'h00;
            end
        end else if (tick) begin
            phase_ff <= phase_ff + 2'd1;
            unique case (st_ff)
                HS_IDLE: begin
                    phase_ff <= 2'd0;
                end
                HS_START: begin
                    if (phase_ff == 2'd0) begin
                        sda_oe_n_ff <= 1'b0;
                    end else begin
                        scl_oe_n_ff <= 1'b0;
                        st_ff <= HS_BIT;
                        phase_ff <= 2'd0;
                    end
                end
                HS_BIT: begin
                    unique case (phase_ff)
                        2'd0: sda_oe_n_ff <= bit_ff == 4'h8 ? 1'b1 : tx_ff[byte_ff][3'd7 - bit_ff[2:0]];
                        2'd1: scl_oe_n_ff <= 1'b1;
                        2'd2: nack_ff <= bit_ff == 4'h8 && link.sda;
                        2'd3: begin
                            scl_oe_n_ff <= 1'b0;
                            if (bit_ff != 4'h8) begin
                                bit_ff <= bit_ff + 4'h1;
                            end else if (nack_ff || byte_ff == 2'd3) begin
                                st_ff <= HS_STOP;
                            end else begin
                                bit_ff <= 4'h0;
                                byte_ff <= byte_ff + 2'd1;
                            end
                        end
                    endcase
                end
                HS_STOP: begin
                    unique case (phase_ff)
                        2'd0: sda_oe_n_ff <= 1'b0;
                        2'd1: scl_oe_n_ff <= 1'b1;
                        2'd2: sda_oe_n_ff <= 1'b1;
                        2'd3: st_ff <= HS_IDLE;
                    endcase
                end
            endcase
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign link.host_scl_o = 1'b0;
    assign link.host_sda_o = 1'b0;
    assign link.host_scl_oe_n = scl_oe_n_ff;
    assign link.host_sda_oe_n = sda_oe_n_ff;

endmodule
`default_nettype wire

//--- src/rfr_router_dev.sv
// Router end: link slave taking route words and driving switch codes.
// Assumes link lines synchronous to pclk and much slower than it.
// Operation
// - Input 1 reaches outputs 1 to 3 only
// - Input 2 reaches outputs 1 to 4 only
// - Input 3 reaches any output 1 to 5
// - Word n alone decides input n path
// - Controller sends zero for unused inputs
// - Nonzero word value names destination output
// - Four switch bits per input, three groups
// - Fixed switch code per output, all inputs
// - Outputs 1 to 3 combine any inputs
// - Output 4 carries inputs 2 and 3 only
// - Output 5 carries input 3 alone
// - Settings arrive over the two-wire link
// - Router never blanks its outputs
// - Cascade input 3 set by controller automatically
// - One router serves up to three channels
`timescale 1ns/1ps
`default_nettype none
`include "rfr_cfg.svh"
module rfr_router_dev
    import rfr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    rfr_link_if.dev link,
    output logic [3:0] path_bits_in1,
    output logic [3:0] path_bits_in2,
    output logic [3:0] path_bits_in3,
    output logic [4:0][2:0] out_feed,
    output logic [2:0] in_connected
);

    // Word legal for input index (0 based)
    function automatic logic route_ok(input logic [1:0] in_idx, input rfr_word_t w);
        route_ok = (w != 8'h00) && (w <= (`RFR_MAX_OUT_IN1 + {6'h00, in_idx}));
    endfunction

    function automatic rfr_code_t route_code(input logic [1:0] in_idx, input rfr_word_t w);
        rfr_code_t c;
        c = `RFR_CODE_OFF;
        if (route_ok(in_idx, w)) begin
            unique case (w[2:0])
                3'h1: c = `RFR_CODE_OUT1;
                3'h2: c = `RFR_CODE_OUT2;
                3'h3: c = `RFR_CODE_OUT3;
                3'h4: c = `RFR_CODE_OUT4;
                3'h5: c = `RFR_CODE_OUT5;
                default: c = `RFR_CODE_OFF;
            endcase
        end
        route_code = c;
    endfunction

    rfr_dev_st_t st_ff;
    logic scl_ff;
    logic sda_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;
    logic [3:0] cnt_ff;
    rfr_word_t shift_ff;
    logic [1:0] idx_ff;
    logic mack_ff;
    logic sda_oe_n_ff;
    rfr_word_t word_ff [`RFR_NUM_IN];
    rfr_code_t code_ff [`RFR_NUM_IN];
    logic [4:0][2:0] feed_ff;
    logic [2:0] conn_ff;

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    logic wr_en;
    rfr_word_t tx_word;

    // Lines are sampled once; two samples give edges and bus conditions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_ff <= link.scl;
            sda_ff <= link.sda;
            scl_prev_ff <= scl_ff;
            sda_prev_ff <= sda_ff;
        end
    end

    assign start_cond = scl_ff && scl_prev_ff && sda_prev_ff && !sda_ff;
    assign stop_cond = scl_ff && scl_prev_ff && !sda_prev_ff && sda_ff;
    assign scl_rise = scl_ff && !scl_prev_ff;
    assign scl_fall = !scl_ff && scl_prev_ff;
    assign wr_en = (st_ff == DS_WR) && scl_fall && (cnt_ff == 4'h8) && (idx_ff < 2'd3);
    assign tx_word = word_ff[idx_ff];

    // Bus protocol: address, write bytes to words in order, or read back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= DS_IDLE;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            idx_ff <= 2'd0;
            mack_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else if (start_cond) begin
            st_ff <= DS_ADDR;
            cnt_ff <= 4'h0;
            idx_ff <= 2'd0;
            sda_oe_n_ff <= 1'b1;
        end else if (stop_cond) begin
            st_ff <= DS_IDLE;
            sda_oe_n_ff <= 1'b1;
        end else begin
            unique case (st_ff)
                DS_IDLE: begin
                    sda_oe_n_ff <= 1'b1;
                end
                DS_ADDR, DS_WR: begin
                    if (scl_rise && cnt_ff != 4'h8) begin
                        shift_ff <= {shift_ff[6:0], sda_ff};
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == 4'h8) begin
                        if (st_ff == DS_ADDR && shift_ff[7:1] == `RFR_DEV_ADDR) begin
                            sda_oe_n_ff <= 1'b0;
                            st_ff <= DS_AACK;
                            mack_ff <= shift_ff[0];
                        end else if (st_ff == DS_WR && idx_ff < 2'd3) begin
                            // Extra bytes beyond the third are refused
                            sda_oe_n_ff <= 1'b0;
                            st_ff <= DS_WACK;
                        end else begin
                            st_ff <= DS_IDLE;
                        end
                    end
                end
                DS_AACK, DS_WACK: begin
                    if (scl_fall) begin
                        cnt_ff <= 4'h0;
                        if (st_ff == DS_WACK) begin
                            idx_ff <= idx_ff + 2'd1;
                        end
                        if (st_ff == DS_AACK && mack_ff) begin
                            st_ff <= DS_TX;
                            sda_oe_n_ff <= tx_word[7];
                            cnt_ff <= 4'h1;
                        end else begin
                            st_ff <= DS_WR;
                            sda_oe_n_ff <= 1'b1;
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (cnt_ff == 4'h8) begin
                            sda_oe_n_ff <= 1'b1;
                            st_ff <= DS_RACK;
                        end else begin
                            sda_oe_n_ff <= tx_word[3'd7 - cnt_ff[2:0]];
                            cnt_ff <= cnt_ff + 4'h1;
                        end
                    end
                end
                DS_RACK: begin
                    if (scl_rise) begin
                        mack_ff <= !sda_ff;
                    end else if (scl_fall) begin
                        if (mack_ff && idx_ff < 2'd2) begin
                            idx_ff <= idx_ff + 2'd1;
                            st_ff <= DS_TX;
                            sda_oe_n_ff <= word_ff[idx_ff + 2'd1][7];
                            cnt_ff <= 4'h1;
                        end else begin
                            st_ff <= DS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Byte n of a write lands only in word n
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `RFR_NUM_IN; i++) begin
                word_ff[i] <= `RFR_WORD_RST;
            end
        end else if (wr_en) begin
            word_ff[idx_ff] <= shift_ff;
        end
    end

    // Switch codes and combine map follow the words one cycle later.
    // No blanking input exists: paths stay static between writes.
    genvar gi;
    genvar go;
    generate
        for (gi = 0; gi < `RFR_NUM_IN; gi++) begin : g_in
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    code_ff[gi] <= `RFR_CODE_OFF;
                    conn_ff[gi] <= 1'b0;
                end else begin
                    code_ff[gi] <= route_code(2'(gi), word_ff[gi]);
                    conn_ff[gi] <= route_ok(2'(gi), word_ff[gi]);
                end
            end
            for (go = 0; go < `RFR_NUM_OUT; go++) begin : g_out
                // Input i may join output o only when legal, so output 4 lacks
                // input 1 and output 5 takes input 3 alone
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        feed_ff[go][gi] <= 1'b0;
                    end else begin
                        feed_ff[go][gi] <= route_ok(2'(gi), word_ff[gi]) && (word_ff[gi] == 8'(go + 1));
                    end
                end
            end
        end
    endgenerate

    assign path_bits_in1 = code_ff[0];
    assign path_bits_in2 = code_ff[1];
    assign path_bits_in3 = code_ff[2];
    assign out_feed = feed_ff;
    assign in_connected = conn_ff;
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe_n = sda_oe_n_ff;

endmodule
`default_nettype wire

//--- verification/rf_router_path_select_tb_top.sv
// Testbench: APB driven controller sends route words to the router end.
// Assumes both ends joined by rfr_link_if; frames take about 38000 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "rfr_cfg.svh"
module rf_router_path_select_tb_top
    import rfr_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] path_bits_in1;
    logic [3:0] path_bits_in2;
    logic [3:0] path_bits_in3;
    logic [4:0][2:0] out_feed;
    logic [2:0] in_connected;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    logic [32:0] aq[$];
    logic [29:0] rq[$];
    logic [32:0] ae;
    logic [29:0] re;
    logic [2:0] r;
    event look;

    rfr_link_if link();
    rfr_route_ctrl u_rfr_route_ctrl(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    rfr_router_dev u_rfr_router_dev(.pclk(pclk), .presetn(presetn), .link(link),
        .path_bits_in1(path_bits_in1), .path_bits_in2(path_bits_in2), .path_bits_in3(path_bits_in3),
        .out_feed(out_feed), .in_connected(in_connected));
    rfr_path_chk u_rfr_path_chk(.pclk(pclk), .presetn(presetn), .scl(link.scl),
        .dev_sda_oe_n(link.dev_sda_oe_n), .path_bits_in1(path_bits_in1), .path_bits_in2(path_bits_in2),
        .path_bits_in3(path_bits_in3), .out_feed(out_feed), .in_connected(in_connected));

    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves one idle cycle so psel never toggles twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [32:0] e);
        logic [31:0] q;
        aq.push_back(e);
        apb(1'b0, a, 32'h0, q);
    endtask

    function automatic logic [3:0] code(input int n, input logic [7:0] w);
        if (w == 8'h0 || w > 8'(n + 3)) return 4'hf;
        return 4'hf - w[3:0];
    endfunction

    task automatic frame(input logic [2:0] w1, w2, w3, used, input logic casc, need);
        logic [31:0] q;
        logic [7:0] ew[3];
        logic [29:0] e;
        logic [3:0] c;
        apb(1'b1, `RFR_REG_WORDS, {21'h0, w3, 1'b0, w2, 1'b0, w1}, q);
        apb(1'b1, `RFR_REG_CTRL, {26'h0, need, used, casc, 1'b1}, q);
        q = 32'h0;
        while (q[`RFR_STAT_DONE] !== 1'b1) apb(1'b0, `RFR_REG_STAT, 32'h0, q);
        rd_chk(`RFR_REG_STAT, {1'b0, 32'h4});
        apb(1'b1, `RFR_REG_STAT, 32'h4, q);
        chk(32'(link.scl), 32'h1);
        ew[0] = used[0] ? {5'h0, w1} : 8'h0;
        ew[1] = used[1] ? {5'h0, w2} : 8'h0;
        // Cascade replaces word 3 with the need of the second router
        ew[2] = casc ? {7'h0, need} : (used[2] ? {5'h0, w3} : 8'h0);
        e = '0;
        for (int n = 0; n < 3; n++) begin
            c = code(n, ew[n]);
            e[11 - 4 * n -: 4] = c;
            if (c != 4'hf) begin
                e[27 + n] = 1'b1;
                e[12 + 3 * (ew[n] - 1) + n] = 1'b1;
            end
        end
        rq.push_back(e);
        -> look;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && aq.size() > 0) begin
            ae = aq.pop_front();
            chk(prdata, ae[31:0]);
            chk(32'(pslverr), 32'(ae[32]));
        end
    end

    always @(look) begin
        re = rq.pop_front();
        chk(32'(path_bits_in1), 32'(re[11:8]));
        chk(32'(path_bits_in2), 32'(re[7:4]));
        chk(32'(path_bits_in3), 32'(re[3:0]));
        chk(32'(out_feed), 32'(re[26:12]));
        chk(32'(in_connected), 32'(re[29:27]));
    end

    // Two frames need about 75000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 95000) begin
            failures++;
            report_and_stop;
        end
    end

    initial begin
        void'($urandom(86469));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rq.push_back({3'h0, 15'h0, 12'hfff});
        -> look;
        rd_chk(`RFR_REG_WORDS, 33'h0);
        rd_chk(`RFR_REG_STAT, 33'h0);
        rd_chk(8'h0c, {1'b1, 32'h0});
        $display("test reset and unmapped done");
        frame(3'h3, 3'h5, 3'h5, 3'b111, 1'b0, 1'b0);
        $display("test limits done");
        r = 3'($urandom % 3) + 3'h1;
        frame(r, r, 3'h7, 3'b011, 1'b1, 1'b1);
        $display("test combine and cascade done");
        report_and_stop;
    end
endmodule
`default_nettype wire

//--- verification/rfr_path_chk.sv
// Checker for the router path select link and router outputs.
// Assumes instantiation beside rfr_link_if with signals passed by name.
`timescale 1ns/1ps
`default_nettype none
module rfr_path_chk
    import rfr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic dev_sda_oe_n,
    input wire logic [3:0] path_bits_in1,
    input wire logic [3:0] path_bits_in2,
    input wire logic [3:0] path_bits_in3,
    input wire logic [4:0][2:0] out_feed,
    input wire logic [2:0] in_connected
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_in1_range; path_bits_in1 inside {4'hc, 4'hd, 4'he, 4'hf}; endproperty
    a_in1_range: assert property (p_in1_range) else $error("input 1 code out of range");
    property p_in2_range; path_bits_in2 != 4'ha; endproperty
    a_in2_range: assert property (p_in2_range) else $error("input 2 reaches output 5");
    property p_in3_conn; in_connected[2] == (path_bits_in3 inside {[4'ha:4'he]}); endproperty
    a_in3_conn: assert property (p_in3_conn) else $error("input 3 connect flag wrong");
    property p_in1_feed;
        out_feed[0][0] == (path_bits_in1 == 4'he) && out_feed[2][0] == (path_bits_in1 == 4'hc);
    endproperty
    a_in1_feed: assert property (p_in1_feed) else $error("input 1 feed disagrees with code");
    property p_out4; !out_feed[3][0]; endproperty
    a_out4: assert property (p_out4) else $error("output 4 carries input 1");
    property p_out5; out_feed[4] == {path_bits_in3 == 4'ha, 2'b00}; endproperty
    a_out5: assert property (p_out5) else $error("output 5 feed wrong");
    // Words only change at the clock fall after the eighth data bit, so the line is low then
    property p_upd_scl_low; !$stable(path_bits_in1) |-> !scl; endproperty
    a_upd_scl_low: assert property (p_upd_scl_low) else $error("code changed with clock high");
    property p_ack_low; $fell(dev_sda_oe_n) |-> !scl ##1 !scl; endproperty
    a_ack_low: assert property (p_ack_low) else $error("router drives data with clock high");
    property p_rst_clear; $rose(presetn) |-> path_bits_in1 == 4'hf && out_feed == '0 && in_connected == 3'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
    property p_in2_conn; in_connected[1] == (|{out_feed[0][1], out_feed[1][1], out_feed[2][1], out_feed[3][1]});
    endproperty
    a_in2_conn: assert property (p_in2_conn) else $error("input 2 feed disagrees with flag");

    c_out5: cover property (out_feed[4][2]);
    c_comb: cover property (out_feed[0] == 3'b111 || out_feed[1] == 3'b011 || out_feed[2] == 3'b011);
    c_ack: cover property ($fell(dev_sda_oe_n));
endmodule
`default_nettype wire
